/* design/mbf_regs.vh */
// Register map, field positions, reset values and limits of the bus status flag bank
`ifndef MBF_REGS_VH
`define MBF_REGS_VH

// Byte offsets on the register bus
`define MBF_OFS_FLAGS 8'h00
`define MBF_OFS_CTRL 8'h04
`define MBF_OFS_CMD 8'h08
`define MBF_OFS_LA_LO 8'h0c
`define MBF_OFS_LA_HI 8'h10

// Field positions in general_status_flags
`define MBF_FLG_CMX 7
`define MBF_FLG_SRQ 5
`define MBF_FLG_SRE 4
`define MBF_FLG_LCK 3
`define MBF_FLG_RSV 2
`define MBF_FLG_RSS 1

// Field positions in bus_control_register and the command register
`define MBF_CTL_RE 0
`define MBF_CMD_SLV_TX 1
`define MBF_CMD_UNLOCK 2

// Reset values
`define MBF_RST_FLAG 1'h0
`define MBF_RST_CTRL 8'h00
`define MBF_RST_ADDR 12'h000
`define MBF_RST_CNT 8'h00

// Largest number of data bytes in one frame
`define MBF_MAX_FRAME_BYTES 8'h20

`endif

/* design/mbf_cmd_ctl.v */
// Command execution tracker for the slave transmit request command
`timescale 1ns/100ps
module mbf_cmd_ctl (
    input wire ref_clk_i,
    input wire rst_i,
    input wire issue_slave_tx_i,
    input wire cmd_done_i,
    output wire cmx_o,
    output wire start_o,
    output wire srq_set_o
);
`include "mbf_regs.vh"

reg cmx_ff;
reg slv_cmd_ff;
reg start_ff;
reg srq_set_ff;

// A command issued while one is still running is dropped
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        cmx_ff <= `MBF_RST_FLAG;
        slv_cmd_ff <= `MBF_RST_FLAG;
        start_ff <= `MBF_RST_FLAG;
        srq_set_ff <= `MBF_RST_FLAG;
    end else begin
        start_ff <= issue_slave_tx_i & ~cmx_ff;
        srq_set_ff <= 1'b0;
        if (issue_slave_tx_i && !cmx_ff) begin
            cmx_ff <= 1'b1;
            slv_cmd_ff <= 1'b1;
        end else if (cmx_ff && cmd_done_i) begin
            cmx_ff <= 1'b0;
            slv_cmd_ff <= 1'b0;
            srq_set_ff <= slv_cmd_ff;
        end
    end
end

assign cmx_o = cmx_ff;
assign start_o = start_ff;
assign srq_set_o = srq_set_ff;

endmodule

/* design/mbf_lock_tracker.v */
// Follows a lock-making frame and reports when the unit becomes locked
`timescale 1ns/100ps
module mbf_lock_tracker (
    input wire ref_clk_i,
    input wire rst_i,
    input wire lock_ctl_rcvd_i,
    input wire [7:0] msg_len_i,
    input wire [11:0] master_addr_i,
    input wire byte_rcvd_i,
    input wire frame_end_i,
    input wire frame_err_i,
    output wire lock_set_o,
    output wire [11:0] lock_addr_o
);
`include "mbf_regs.vh"

reg armed_ff;
reg [7:0] need_ff;
reg [7:0] got_ff;
reg [11:0] addr_ff;
reg [11:0] lock_addr_ff;
reg lock_set_ff;
wire short_frame;

// Only a message too long for one frame can lock the unit
assign short_frame = (got_ff < need_ff) && (need_ff > `MBF_MAX_FRAME_BYTES);

always @(posedge ref_clk_i) begin
    if (rst_i) begin
        armed_ff <= `MBF_RST_FLAG;
        need_ff <= `MBF_RST_CNT;
        got_ff <= `MBF_RST_CNT;
        addr_ff <= `MBF_RST_ADDR;
        lock_addr_ff <= `MBF_RST_ADDR;
        lock_set_ff <= `MBF_RST_FLAG;
    end else begin
        lock_set_ff <= 1'b0;
        if (lock_ctl_rcvd_i) begin
            armed_ff <= 1'b1;
            need_ff <= msg_len_i;
            got_ff <= `MBF_RST_CNT;
            addr_ff <= master_addr_i;
        end else if (armed_ff && frame_err_i) begin
            armed_ff <= 1'b0;
        end else if (armed_ff && frame_end_i) begin
            armed_ff <= 1'b0;
            if (short_frame) begin
                lock_set_ff <= 1'b1;
                lock_addr_ff <= addr_ff;
            end
        end else if (armed_ff && byte_rcvd_i && got_ff != 8'hff) begin
            got_ff <= got_ff + 8'h01;
        end
    end
end

assign lock_set_o = lock_set_ff;
assign lock_addr_o = lock_addr_ff;

endmodule

/* design/mbf_status_flags.v */
// Status flag register bank of the multiplex bus controller with its Wishbone slave
`timescale 1ns/100ps
module mbf_status_flags (
    input wire ref_clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    input wire cmd_done_i,
    input wire slave_tx_done_i,
    input wire rx_start_i,
    input wire rx_done_i,
    input wire rx_bcast_bit_i,
    input wire lock_ctl_rcvd_i,
    input wire [7:0] msg_len_i,
    input wire [11:0] lock_master_addr_i,
    input wire byte_rcvd_i,
    input wire frame_end_i,
    input wire frame_err_i,
    input wire unlock_cond_i,
    output wire slave_tx_cmd_o,
    output wire unlock_cmd_o,
    output wire reception_started_flag_o,
    output wire receive_enable_ctl_o,
    output wire command_executing_o,
    output wire slave_tx_pending_o,
    output wire slave_rx_active_o,
    output wire unit_locked_o,
    output wire captured_broadcast_bit_o
);
`include "mbf_regs.vh"

// Register selects
localparam SEL_NONE = 3'h0;
localparam SEL_FLAGS = 3'h1;
localparam SEL_CTRL = 3'h2;
localparam SEL_CMD = 3'h3;
localparam SEL_LA_LO = 3'h4;
localparam SEL_LA_HI = 3'h5;

// Control reset value as a vector, so that one field can be picked without truncation
localparam [7:0] RST_CTRL = `MBF_RST_CTRL;

// Decode of a byte address into a register select
function [2:0] reg_sel;
    input [7:0] adr;
    begin
        case (adr)
            `MBF_OFS_FLAGS: begin
                reg_sel = SEL_FLAGS;
            end
            `MBF_OFS_CTRL: begin
                reg_sel = SEL_CTRL;
            end
            `MBF_OFS_CMD: begin
                reg_sel = SEL_CMD;
            end
            `MBF_OFS_LA_LO: begin
                reg_sel = SEL_LA_LO;
            end
            `MBF_OFS_LA_HI: begin
                reg_sel = SEL_LA_HI;
            end
            default: begin
                reg_sel = SEL_NONE;
            end
        endcase
    end
endfunction

// Bus slave state
reg ack_ff;
reg [31:0] rdata_ff;
reg [31:0] nxt_rdata;
wire req;
wire wr_lane0;
wire [2:0] sel;

// Control and flag state
reg rx_en_ff;
reg srq_ff;
reg sre_ff;
reg lck_ff;
reg rss_ff;
reg rxs_ff;
reg unlock_cmd_ff;
reg nxt_srq;
reg nxt_sre;
reg nxt_lck;
reg nxt_rss;

// Sub-block connections
wire issue_slave_tx;
wire issue_unlock;
wire command_executing;
wire srq_set;
wire slave_tx_start;
wire lock_set;
wire [11:0] lock_addr;
wire rx_begin;
wire [7:0] flags_byte;

// A new request is taken only in the cycle before ack, so each one is acked once
assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
assign sel = reg_sel(wb_adr_i);
assign wr_lane0 = req & wb_we_i & wb_sel_i[0];

// Commands are one-shot; the command register stores nothing
assign issue_slave_tx = wr_lane0 && (sel == SEL_CMD) && wb_dat_i[`MBF_CMD_SLV_TX];
assign issue_unlock = wr_lane0 && (sel == SEL_CMD) && wb_dat_i[`MBF_CMD_UNLOCK];

// Reception counts as started only while reception is enabled
assign rx_begin = rx_start_i & rx_en_ff;

mbf_cmd_ctl u_cmd (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .issue_slave_tx_i(issue_slave_tx),
    .cmd_done_i(cmd_done_i),
    .cmx_o(command_executing),
    .start_o(slave_tx_start),
    .srq_set_o(srq_set)
);

mbf_lock_tracker u_lock (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .lock_ctl_rcvd_i(lock_ctl_rcvd_i),
    .msg_len_i(msg_len_i),
    .master_addr_i(lock_master_addr_i),
    .byte_rcvd_i(byte_rcvd_i),
    .frame_end_i(frame_end_i),
    .frame_err_i(frame_err_i),
    .lock_set_o(lock_set),
    .lock_addr_o(lock_addr)
);

// Flag byte as software sees it; bits 6, 2 and 0 belong to other logic and read 0
assign flags_byte = {
    command_executing,
    1'b0,
    srq_ff,
    sre_ff,
    lck_ff,
    1'b0,
    rss_ff,
    1'b0
};

// Next-state of the flags; every set wins over a clear in the same cycle
always @* begin
    nxt_srq = srq_ff;
    if (srq_set) begin
        nxt_srq = 1'b1;
    end else if (slave_tx_done_i) begin
        nxt_srq = 1'b0;
    end
    nxt_sre = sre_ff;
    if (rx_begin) begin
        nxt_sre = 1'b1;
    end else if (rx_done_i) begin
        nxt_sre = 1'b0;
    end
    nxt_lck = lck_ff;
    if (lock_set) begin
        nxt_lck = 1'b1;
    end else if (unlock_cond_i || issue_unlock) begin
        nxt_lck = 1'b0;
    end
    nxt_rss = rss_ff;
    if (rx_begin) begin
        nxt_rss = rx_bcast_bit_i;
    end
end

// Flag registers; a bus write reaches them only through the command register
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        srq_ff <= `MBF_RST_FLAG;
        sre_ff <= `MBF_RST_FLAG;
        lck_ff <= `MBF_RST_FLAG;
        rss_ff <= `MBF_RST_FLAG;
        rxs_ff <= `MBF_RST_FLAG;
    end else begin
        srq_ff <= nxt_srq;
        sre_ff <= nxt_sre;
        lck_ff <= nxt_lck;
        rss_ff <= nxt_rss;
        rxs_ff <= rx_begin;
    end
end

// Control register and command strobe toward the bus engine
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        rx_en_ff <= RST_CTRL[`MBF_CTL_RE];
        unlock_cmd_ff <= `MBF_RST_FLAG;
    end else begin
        unlock_cmd_ff <= issue_unlock;
        if (wr_lane0 && sel == SEL_CTRL) begin
            rx_en_ff <= wb_dat_i[`MBF_CTL_RE];
        end
    end
end

// Read mux; addresses outside the map read as zero
always @* begin
    nxt_rdata = 32'h0000_0000;
    case (sel)
        SEL_FLAGS: begin
            nxt_rdata[7:0] = flags_byte;
        end
        SEL_CTRL: begin
            nxt_rdata[`MBF_CTL_RE] = rx_en_ff;
        end
        SEL_LA_LO: begin
            nxt_rdata[7:0] = lock_addr[7:0];
        end
        SEL_LA_HI: begin
            nxt_rdata[3:0] = lock_addr[11:8];
        end
        default: begin
            nxt_rdata = 32'h0000_0000;
        end
    endcase
end

// One wait state: ack and data come from flops in the cycle after the request
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        ack_ff <= 1'b0;
        rdata_ff <= 32'h0000_0000;
    end else begin
        ack_ff <= req;
        if (req && !wb_we_i) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end
end

assign wb_ack_o = ack_ff;
assign wb_dat_o = rdata_ff;
assign slave_tx_cmd_o = slave_tx_start;
assign unlock_cmd_o = unlock_cmd_ff;
assign reception_started_flag_o = rxs_ff;
assign receive_enable_ctl_o = rx_en_ff;
assign command_executing_o = command_executing;
assign slave_tx_pending_o = srq_ff;
assign slave_rx_active_o = sre_ff;
assign unit_locked_o = lck_ff;
assign captured_broadcast_bit_o = rss_ff;

endmodule

/* test/mbf_status_flags_monitor.sv */
// Concurrent checks on the status flag bank ports
`timescale 1ns/100ps
module mbf_status_flags_monitor (
    input wire ref_clk_i,
    input wire rst_i,
    input wire slave_tx_done_i,
    input wire rx_start_i,
    input wire rx_bcast_bit_i,
    input wire rx_done_i,
    input wire frame_end_i,
    input wire unlock_cond_i,
    input wire reception_started_flag_o,
    input wire receive_enable_ctl_o,
    input wire command_executing_o,
    input wire slave_tx_pending_o,
    input wire slave_rx_active_o,
    input wire unit_locked_o,
    input wire captured_broadcast_bit_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    // A reception start only counts while receive enable is on
    wire go = rx_start_i & receive_enable_ctl_o;
    property p_srq_set; $fell(command_executing_o) |=> slave_tx_pending_o; endproperty
    a_srq_set: assert property (p_srq_set) else $error("srq not set");
    property p_srq_clr; slave_tx_done_i && !$fell(command_executing_o) |=> !slave_tx_pending_o;
    endproperty
    a_srq_clr: assert property (p_srq_clr) else $error("srq not cleared");
    property p_sre_set; go |=> slave_rx_active_o && reception_started_flag_o; endproperty
    a_sre_set: assert property (p_sre_set) else $error("sre not set");
    property p_sre_clr; rx_done_i && !go |=> !slave_rx_active_o; endproperty
    a_sre_clr: assert property (p_sre_clr) else $error("sre not cleared");
    property p_rss_cap; go |=> captured_broadcast_bit_o == $past(rx_bcast_bit_i); endproperty
    a_rss_cap: assert property (p_rss_cap) else $error("rss not captured");
    property p_rss_hold; !go |=> $stable(captured_broadcast_bit_o); endproperty
    a_rss_hold: assert property (p_rss_hold) else $error("rss changed");
    // Lock can only come from a frame end two cycles back
    property p_lck_set; $rose(unit_locked_o) |-> $past(frame_end_i, 2); endproperty
    a_lck_set: assert property (p_lck_set) else $error("lock without frame end");
    property p_lck_clr; unlock_cond_i && !$past(frame_end_i) |=> !unit_locked_o; endproperty
    a_lck_clr: assert property (p_lck_clr) else $error("lock not cleared");
    cover property (slave_tx_pending_o);
    cover property (go && rx_bcast_bit_i);
    cover property ($rose(unit_locked_o));
endmodule
bind mbf_status_flags mbf_status_flags_monitor u_mbf_status_flags_monitor (.*);

/* test/mbf_bus_peer.sv */
// Far-side bus units: receptions, lock frames and bus events
`timescale 1ns/100ps
module mbf_bus_peer (
    input wire ref_clk_i,
    output logic rx_start_o,
    output logic rx_bcast_o,
    output logic rx_done_o,
    output logic lock_ctl_o,
    output logic [7:0] msg_len_o,
    output logic [11:0] addr_o,
    output logic byte_o,
    output logic frame_end_o,
    output logic frame_err_o,
    output logic unlock_o,
    output logic tx_done_o
);
    initial begin
        {rx_start_o, rx_bcast_o, rx_done_o, lock_ctl_o, byte_o} = 5'h00;
        {frame_end_o, frame_err_o, unlock_o, tx_done_o, msg_len_o, addr_o} = 24'h000000;
    end
    // Broadcast line is inverted once the start is past, so a late sample shows
    task rx(input logic b);
        rx_bcast_o <= b;
        rx_start_o <= 1'b1;
        @(posedge ref_clk_i);
        rx_start_o <= 1'b0;
        rx_bcast_o <= ~b;
        repeat (3) @(posedge ref_clk_i);
        rx_done_o <= 1'b1;
        @(posedge ref_clk_i);
        rx_done_o <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task frame(input logic [7:0] len, input logic [7:0] n, input logic [11:0] a, input logic e);
        lock_ctl_o <= 1'b1;
        msg_len_o <= len;
        addr_o <= a;
        @(posedge ref_clk_i);
        lock_ctl_o <= 1'b0;
        msg_len_o <= ~len;
        addr_o <= ~a;
        repeat (n) begin
            byte_o <= 1'b1;
            @(posedge ref_clk_i);
        end
        byte_o <= 1'b0;
        frame_end_o <= !e;
        frame_err_o <= e;
        @(posedge ref_clk_i);
        frame_end_o <= 1'b0;
        frame_err_o <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
    endtask
    task evt(input logic unl);
        unlock_o <= unl;
        tx_done_o <= !unl;
        @(posedge ref_clk_i);
        unlock_o <= 1'b0;
        tx_done_o <= 1'b0;
        @(posedge ref_clk_i);
    endtask
endmodule

/* test/mbf_status_flags_tb_top.sv */
// Self-checking bench of the status flag bank
`timescale 1ns/100ps
`include "mbf_regs.vh"
module mbf_status_flags_tb_top;
    logic ref_clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, cmd_done_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [3:0] lane = 4'hf;
    logic [1:0] pl;
    wire slave_tx_cmd_o, unlock_cmd_o;
    logic [31:0] wb_dat_i, q;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, slave_tx_done_i, rx_start_i, rx_done_i, rx_bcast_bit_i, lock_ctl_rcvd_i;
    wire byte_rcvd_i, frame_end_i, frame_err_i, unlock_cond_i;
    wire [7:0] msg_len_i;
    wire [11:0] lock_master_addr_i;
    wire reception_started_flag_o, receive_enable_ctl_o, command_executing_o;
    wire slave_tx_pending_o, slave_rx_active_o, unit_locked_o, captured_broadcast_bit_o;
    int n_errors = 0;
    int checks = 0;
    mbf_status_flags u_mbf_status_flags (.*);
    mbf_bus_peer u_mbf_bus_peer (.ref_clk_i, .rx_start_o(rx_start_i), .rx_bcast_o(rx_bcast_bit_i),
        .rx_done_o(rx_done_i), .lock_ctl_o(lock_ctl_rcvd_i), .msg_len_o(msg_len_i),
        .addr_o(lock_master_addr_i), .byte_o(byte_rcvd_i), .frame_end_o(frame_end_i),
        .frame_err_o(frame_err_i), .unlock_o(unlock_cond_i), .tx_done_o(slave_tx_done_i));
    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <= {1'b1, 1'b1, w, lane, a, d};
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        // Command strobes toward the engine stand in the ack cycle
        pl = {slave_tx_cmd_o, unlock_cmd_o};
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        @(posedge ref_clk_i);
        if (n >= 50) n_errors++;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    // Flag word from {cmx, srq, sre, lck, rss}; bits 6, 2 and 0 read 0
    function automatic logic [31:0] fw(input logic [4:0] f);
        return {24'h0, f[4], 1'b0, f[3:1], 1'b0, f[0], 1'b0};
    endfunction
    task t_reset;
        rd(`MBF_OFS_FLAGS, 32'h0);
        wb(1'b1, `MBF_OFS_FLAGS, 32'hff);
        wb(1'b1, 8'h40, 32'hff);
        rd(`MBF_OFS_FLAGS, 32'h0);
        rd(`MBF_OFS_LA_LO, 32'h0);
        rd(8'h40, 32'h0);
        $display("t_reset done");
    endtask
    task t_srq;
        wb(1'b1, `MBF_OFS_CMD, 32'h2);
        chk({30'h0, pl}, 32'h2);
        rd(`MBF_OFS_FLAGS, fw(5'h10));
        wb(1'b1, `MBF_OFS_CMD, 32'h2);
        chk({30'h0, pl}, 32'h0);
        rd(`MBF_OFS_CMD, 32'h0);
        cmd_done_i <= 1'b1;
        @(posedge ref_clk_i);
        cmd_done_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        rd(`MBF_OFS_FLAGS, fw(5'h08));
        u_mbf_bus_peer.evt(1'b0);
        rd(`MBF_OFS_FLAGS, 32'h0);
        $display("t_srq done");
    endtask
    task t_rx;
        lane = 4'he;
        wb(1'b1, `MBF_OFS_CTRL, 32'h1);
        lane = 4'hf;
        rd(`MBF_OFS_CTRL, 32'h0);
        u_mbf_bus_peer.rx(1'b1);
        rd(`MBF_OFS_FLAGS, 32'h0);
        wb(1'b1, `MBF_OFS_CTRL, 32'h1);
        rd(`MBF_OFS_CTRL, 32'h1);
        u_mbf_bus_peer.rx(1'b1);
        rd(`MBF_OFS_FLAGS, fw(5'h01));
        u_mbf_bus_peer.rx(1'b0);
        rd(`MBF_OFS_FLAGS, 32'h0);
        $display("t_rx done");
    endtask
    task t_lock;
        u_mbf_bus_peer.frame(8'h20, 8'h2, 12'h5c3, 1'b0);
        rd(`MBF_OFS_FLAGS, 32'h0);
        u_mbf_bus_peer.frame(8'h21, 8'h3, 12'h5c3, 1'b0);
        rd(`MBF_OFS_FLAGS, fw(5'h02));
        rd(`MBF_OFS_LA_LO, 32'hc3);
        rd(`MBF_OFS_LA_HI, 32'h5);
        u_mbf_bus_peer.frame(8'h28, 8'h2, 12'h111, 1'b1);
        rd(`MBF_OFS_FLAGS, fw(5'h02));
        u_mbf_bus_peer.evt(1'b1);
        rd(`MBF_OFS_FLAGS, 32'h0);
        u_mbf_bus_peer.frame(8'h28, 8'h28, 12'h111, 1'b0);
        rd(`MBF_OFS_FLAGS, 32'h0);
        u_mbf_bus_peer.frame(8'h28, 8'h1, 12'h111, 1'b0);
        wb(1'b1, `MBF_OFS_CMD, 32'h4);
        chk({30'h0, pl}, 32'h1);
        rd(`MBF_OFS_FLAGS, 32'h0);
        $display("t_lock done");
    endtask
    // Reset in mid-run while flags and control are set
    task t_mid_reset;
        u_mbf_bus_peer.frame(8'h30, 8'h4, 12'habc, 1'b0);
        wb(1'b1, `MBF_OFS_CTRL, 32'h1);
        u_mbf_bus_peer.rx(1'b1);
        rd(`MBF_OFS_FLAGS, fw(5'h03));
        rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        rd(`MBF_OFS_FLAGS, 32'h0);
        rd(`MBF_OFS_CTRL, 32'h0);
        rd(`MBF_OFS_LA_LO, 32'h0);
        $display("t_mid_reset done");
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        finish_test;
    end
    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, cmd_done_i, wb_adr_i, wb_dat_i} = 45'h100000000000;
        wb_sel_i = 4'hf;
        repeat (16) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        t_reset;
        t_srq;
        t_rx;
        t_lock;
        t_mid_reset;
        finish_test;
    end
endmodule
